// ===== rtl/lrr_pkg.sv
// Package for the literal/return/rotate execution slice.
// Assumes a 14-bit instruction word, 8-bit data path, 7-bit file address.
package lrr_pkg;
    localparam int          INSN_W         = 14;
    localparam int          DATA_W         = 8;
    localparam int          FADDR_W        = 7;
    localparam int          PC_W           = 13;
    // Opcode fields
    localparam logic [3:0]  OPC_LIT_MOVE   = 4'hc;   // 11 00xx
    localparam logic [3:0]  OPC_LIT_RET    = 4'hd;   // 11 01xx
    localparam logic [5:0]  OPC_ROT_LEFT   = 6'h0d;  // 00 1101
    localparam logic [6:0]  OPC_STORE_W    = 7'h01;  // 00 0000 1
    localparam int          OPC4_LSB       = 10;
    localparam int          OPC6_LSB       = 8;
    localparam int          OPC7_LSB       = 7;
    localparam int          DEST_BIT       = 7;
    // Reset values
    localparam logic [7:0]  WORK_RST       = 8'h00;
    localparam logic        CARRY_RST      = 1'b0;
    // Cycle counts
    localparam int          RET_CYCLES     = 2;

    typedef enum logic [2:0] {
        LRR_OP_NONE,
        LRR_OP_LOAD_LITERAL,
        LRR_OP_RETURN_LITERAL,
        LRR_OP_ROTATE_LEFT,
        LRR_OP_STORE_WORK
    } lrr_op_t;

    typedef struct packed {
        logic               we;
        logic [6:0]         addr;
        logic [7:0]         data;
    } lrr_file_wr_t;
endpackage : lrr_pkg

// ===== rtl/lrr_decode.sv
// Instruction decoder for the execution slice.
// Assumes a fetched word that is stable for the whole cycle.
`timescale 1ns/1ps
module lrr_decode
    import lrr_pkg::*;
(
    // Instruction
    input  wire logic [13:0]    insn,
    // Decoded fields
    output lrr_pkg::lrr_op_t    op,
    output logic [7:0]          literal,
    output logic [6:0]          faddr,
    output logic                dest_file
);
    always_comb begin
        literal   = insn[7:0];
        faddr     = insn[6:0];
        dest_file = insn[DEST_BIT];
        // Bits 9:8 are never looked at for literal forms
        if (insn[13:OPC4_LSB] == OPC_LIT_MOVE) begin
            op = LRR_OP_LOAD_LITERAL;
        end else if (insn[13:OPC4_LSB] == OPC_LIT_RET) begin
            op = LRR_OP_RETURN_LITERAL;
        end else if (insn[13:OPC6_LSB] == OPC_ROT_LEFT) begin
            op = LRR_OP_ROTATE_LEFT;
        end else if (insn[13:OPC7_LSB] == OPC_STORE_W) begin
            op = LRR_OP_STORE_WORK;
        end else begin
            op = LRR_OP_NONE;
        end
    end
endmodule : lrr_decode

// ===== rtl/lrr_exec.sv
// Execution slice: literal load, return with literal, store W, rotate left.
// Assumes the core supplies a fetched word each cycle, a combinational
// file read port and a return stack that pops on a one-cycle strobe.
`timescale 1ns/1ps
module lrr_exec
    import lrr_pkg::*;
(
    // Clock and reset
    input  wire logic                   clk_sys,
    input  wire logic                   sys_rst,
    // Instruction fetch
    input  wire logic [13:0]            insn,
    input  wire logic                   insn_valid,
    // Return stack
    input  wire logic [12:0]            stack_top_entry,
    output logic                        stack_pop,
    output logic                        pc_load,
    output logic [12:0]                 pc_new,
    output logic                        fetch_flush,
    // File register port
    output logic [6:0]                  file_raddr,
    input  wire logic [7:0]             file_rdata,
    output lrr_pkg::lrr_file_wr_t       file_wr,
    // Core state
    output logic [7:0]                  work_q,
    output logic                        carry_q,
    output logic                        busy
);
    import lrr_pkg::*;

    lrr_op_t        op;
    logic [7:0]     literal;
    logic [6:0]     faddr;
    logic           dest_file;
    logic           flush_q;
    logic           exec;
    logic [7:0]     rot_val;
    logic [12:0]    pc_new_q;
    logic           pc_load_q;
    lrr_file_wr_t   file_wr_q;

    initial begin
        if (RET_CYCLES != 2) begin
            $error("lrr_exec supports a two-cycle return only");
        end
    end

    lrr_decode u_decode (
        .insn      (insn),
        .op        (op),
        .literal   (literal),
        .faddr     (faddr),
        .dest_file (dest_file)
    );

    // Second cycle of a return executes nothing: prefetched word is dropped
    assign exec        = insn_valid && !flush_q;
    assign file_raddr  = faddr;
    assign rot_val     = {file_rdata[6:0], carry_q};
    assign stack_pop   = exec && (op == LRR_OP_RETURN_LITERAL);
    assign fetch_flush = stack_pop;
    assign busy        = flush_q;
    assign pc_load     = pc_load_q;
    assign pc_new      = pc_new_q;
    assign file_wr     = file_wr_q;

    // Return sequencing
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            flush_q   <= 1'b0;
            pc_load_q <= 1'b0;
            pc_new_q  <= '0;
        end else begin
            flush_q   <= stack_pop;
            pc_load_q <= stack_pop;
            if (stack_pop) begin
                pc_new_q <= stack_top_entry;
            end
        end
    end

    // Working register
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            work_q <= WORK_RST;
        end else if (exec) begin
            case (op)
                LRR_OP_LOAD_LITERAL: begin
                    work_q <= literal;
                end
                LRR_OP_RETURN_LITERAL: begin
                    work_q <= literal;
                end
                LRR_OP_ROTATE_LEFT: begin
                    if (!dest_file) begin
                        work_q <= rot_val;
                    end
                end
                default: begin
                end
            endcase
        end
    end

    // Carry: only rotate touches flags
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            carry_q <= CARRY_RST;
        end else if (exec && op == LRR_OP_ROTATE_LEFT) begin
            carry_q <= file_rdata[7];
        end
    end

    // File write strobe, registered so data comes from flops
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            file_wr_q <= '0;
        end else begin
            file_wr_q.we   <= 1'b0;
            file_wr_q.addr <= faddr;
            file_wr_q.data <= work_q;
            if (exec && op == LRR_OP_STORE_WORK) begin
                file_wr_q.we <= 1'b1;
            end else if (exec && op == LRR_OP_ROTATE_LEFT && dest_file) begin
                file_wr_q.we   <= 1'b1;
                file_wr_q.data <= rot_val;
            end
        end
    end
endmodule : lrr_exec

// ===== tb/lrr_exec_props.sv
// Assertions on lrr_exec ports.
// Assumes a bind by port name.
`timescale 1ns/1ps
module lrr_exec_props (
    // Watched ports
    input wire logic clk_sys, sys_rst, insn_valid, stack_pop, pc_load,
    input wire logic fetch_flush, carry_q, busy,
    input wire logic [13:0] insn,
    input wire logic [12:0] stack_top_entry, pc_new,
    input wire logic [7:0] file_rdata, work_q,
    input wire lrr_pkg::lrr_file_wr_t file_wr
);
    logic go;
    logic [7:0] rot;
    assign go = insn_valid && !busy;
    assign rot = {file_rdata[6:0], carry_q};
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (sys_rst);
    a_load_lit: assert property (
        go && insn[13:10] == 4'hc |=> work_q == $past(insn[7:0]) && $stable(carry_q))
        else $error("load");
    a_ret_pop: assert property (go && insn[13:10] == 4'hd |-> stack_pop && fetch_flush)
        else $error("pop");
    a_ret_pc: assert property (
        stack_pop |=> pc_load && pc_new == $past(stack_top_entry) && work_q == $past(insn[7:0]))
        else $error("ret");
    a_ret_two: assert property (stack_pop |=> busy ##1 !busy) else $error("two");
    a_busy_drop: assert property (busy |-> !stack_pop ##1 !file_wr.we) else $error("d");
    a_rot_work: assert property (
        go && insn[13:7] == 7'h1a |=> work_q == $past(rot) && carry_q == $past(file_rdata[7]))
        else $error("rotw");
    a_rot_file: assert property (
        go && insn[13:7] == 7'h1b |=> file_wr == {1'b1, $past(insn[6:0]), $past(rot)})
        else $error("rotf");
    a_store_w: assert property (
        go && insn[13:7] == 7'h01 |=> file_wr == {1'b1, $past(insn[6:0]), $past(work_q)})
        else $error("store");
endmodule : lrr_exec_props
bind lrr_exec lrr_exec_props u_props (.*);

// ===== tb/lrr_exec_tb.sv
// Self-checking bench for lrr_exec.
// Assumes lrr_pkg and the checker compile first.
`timescale 1ns/1ps
module lrr_exec_tb;
    logic clk_sys = 0, sys_rst = 1, insn_valid = 0, stack_pop, pc_load, fetch_flush, carry_q, busy;
    logic [13:0] insn = 0;
    logic [12:0] stack_top_entry = 0, pc_new;
    logic [7:0] file_rdata = 0, work_q;
    lrr_pkg::lrr_file_wr_t file_wr;
    logic [9:0] e = 0;
    lrr_pkg::lrr_file_wr_t ew;
    logic [12:0] ep;
    logic acc, er;
    logic [31:0] w;
    logic [13:0] cw [4] = '{14'h3fff, 14'h3780, 14'h34c3, 14'h0dff};
    int fails = 0, compares = 0;
    always #12.5 clk_sys = ~clk_sys;
    lrr_exec dut (.*, .file_raddr());
    function automatic logic [9:0] nx(logic [13:0] i, logic v);
        logic [9:0] n = {1'b0, e[8:0]};
        if (v && !e[9] && i[13:11] == 3'h6) n = {i[10], i[7:0], e[0]};
        if (v && !e[9] && i[13:8] == 6'h0d)
            n = {1'b0, i[7] ? e[8:1] : {file_rdata[6:0], e[0]}, file_rdata[7]};
        return n;
    endfunction : nx
    task automatic print_verdict;
        if (fails == 0 && compares > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : print_verdict
    task automatic cy(logic [13:0] i, logic v);
        insn = i;
        insn_valid = v;
        {file_rdata, stack_top_entry} = 21'($urandom);
        acc = v && !e[9];
        er = acc && i[13:10] == 4'hd;
        ep = er ? stack_top_entry : 13'h0;
        ew = '0;
        if (acc && i[13:7] == 7'h01) ew = {1'b1, i[6:0], e[8:1]};
        if (acc && i[13:7] == 7'h1b) ew = {1'b1, i[6:0], file_rdata[6:0], e[0]};
        e = nx(i, v);
        #5;
        compares++;
        if ({stack_pop, fetch_flush} !== {er, er}) begin
            fails++;
            $display("mismatch %0t %h %h", $time, {stack_pop, fetch_flush}, {er, er});
        end
        @(posedge clk_sys) #1;
        compares++;
        if ({file_wr.we, file_wr.we ? file_wr[14:0] : 15'h0} !== ew) begin
            fails++;
            $display("mismatch %0t %h %h", $time, file_wr, ew);
        end
        compares++;
        if ({pc_load, pc_load ? pc_new : 13'h0} !== {er, ep}) begin
            fails++;
            $display("mismatch %0t %h %h", $time, {pc_load, pc_new}, {er, ep});
        end
        compares++;
        if ({busy, work_q, carry_q} !== e) begin
            fails++;
            $display("mismatch %0t %h %h", $time, {busy, work_q, carry_q}, e);
        end
    endtask : cy
    initial begin
        void'($urandom(48));
        repeat (5) @(posedge clk_sys);
        #1 sys_rst = 0;
        // A return right behind a return is dropped while busy
        foreach (cw[k]) cy(cw[k], 1'b1);
        repeat (3000) begin
            w = $urandom;
            if (w[16]) w[13:11] = 3'h6;
            else if (w[17]) w[13:8] = 6'h0d;
            else if (w[18]) w[13:7] = 7'h01;
            cy(w[13:0], |w[21:20]);
        end
        print_verdict;
    end
    initial begin
        #150000;
        fails++;
        print_verdict;
    end
endmodule : lrr_exec_tb
